// file: mcb_config_bits.v
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mcb_defs.vh"
module mcb_config_bits (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  // register port
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  // pins and steered logic
  input wire y_energy_pulse,
  input wire pin_nine_gpio_out,
  output reg digital_pin_nine,
  input wire emu_clk_in,
  output reg emu_clk_gate,
  input wire emu_erase_req,
  input wire emu_prog_req,
  output reg emu_erase_grant,
  output reg emu_prog_grant,
  output reg [2:0] power_equation_select,
  output reg [7:0] serial_rom_data,
  output reg [7:0] serial_rom_control,
  input wire fast_clock_flag,
  input wire mid_clock_flag,
  output reg [1:0] decimation_length_select,
  output reg [8:0] decimation_cycles,
  // interrupt sources and processor enables: xfer, rtc, firmware_collision_event, pll
  input wire [3:0] irq_src,
  input wire [3:0] cpu_irq_enable,
  output reg [3:0] cpu_irq,
  output reg irq
);
  reg [7:0] rom_data_reg;
  reg [7:0] rom_ctrl_reg;
  reg [2:0] equ_reg;
  reg [3:0] ien_reg;
  reg eck_off_reg;
  reg [1:0] fir_reg;
  reg py_sel_reg;
  reg [3:0] stat_reg;
  reg [3:0] mask_reg;
  reg [3:0] src_d_reg;
  reg [7:0] rd_next;
  reg [8:0] cyc_next;
  wire alt_mode = ~fast_clock_flag & mid_clock_flag;
  wire [3:0] src_rise = irq_src & ~src_d_reg;
  wire wr_stat = wr_stb && addr == `MCB_OFF_IRQ_STAT;

  always @* begin
    case ({alt_mode, fir_reg}) // RULE8
      3'b000: cyc_next = `MCB_FIR_CYC_00;
      3'b001: cyc_next = `MCB_FIR_CYC_01;
      3'b010: cyc_next = `MCB_FIR_CYC_10;
      3'b100: cyc_next = `MCB_FIR_ALT_00;
      3'b101: cyc_next = `MCB_FIR_ALT_01;
      default: cyc_next = 9'h000; // undefined code: no filter length
    endcase
  end

  always @* begin
    rd_next = 8'h00; // RULE9
    case (addr)
      `MCB_OFF_ROM_DATA: rd_next = rom_data_reg;
      `MCB_OFF_ROM_CTRL: rd_next = rom_ctrl_reg;
      `MCB_OFF_EQU: rd_next[`MCB_EQU_LSB +: 3] = equ_reg;
      `MCB_OFF_IEN_A: rd_next[1:0] = ien_reg[1:0];
      `MCB_OFF_ECK: rd_next[`MCB_ECK_BIT] = eck_off_reg;
      `MCB_OFF_IEN_B: begin
        rd_next[`MCB_FIRMWARE_COLLISION_EVENT_BIT] = ien_reg[2];
        rd_next[`MCB_PLL_BIT] = ien_reg[3];
        rd_next[`MCB_FIR_LSB +: 2] = fir_reg;
      end
      `MCB_OFF_PULSE: rd_next[`MCB_PY_BIT] = py_sel_reg;
      `MCB_OFF_IRQ_STAT: rd_next[3:0] = stat_reg;
      `MCB_OFF_IRQ_MASK: rd_next[3:0] = mask_reg;
      `MCB_OFF_FIR_CYC: rd_next = cyc_next[8:1]; // cycles halved to fit a byte
      default: rd_next = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_data_reg <= 8'h00; // RULE2
      rom_ctrl_reg <= 8'h00; // RULE2
      equ_reg <= 3'h0; // RULE5
      ien_reg <= 4'h0; // RULE6
      eck_off_reg <= 1'b0;
      fir_reg <= `MCB_FIR_RESET; // RULE8
      py_sel_reg <= 1'b0;
      stat_reg <= 4'h0;
      mask_reg <= 4'h0;
      src_d_reg <= 4'h0;
      rdata <= 8'h00;
      digital_pin_nine <= 1'b0;
      emu_clk_gate <= 1'b0;
      emu_erase_grant <= 1'b0;
      emu_prog_grant <= 1'b0;
      power_equation_select <= 3'h0;
      serial_rom_data <= 8'h00;
      serial_rom_control <= 8'h00;
      decimation_length_select <= `MCB_FIR_RESET;
      decimation_cycles <= `MCB_FIR_CYC_01;
      cpu_irq <= 4'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr_stb) begin // RULE9
        case (addr)
          `MCB_OFF_ROM_DATA: rom_data_reg <= wdata; // RULE2
          `MCB_OFF_ROM_CTRL: rom_ctrl_reg <= wdata; // RULE2
          `MCB_OFF_EQU: equ_reg <= wdata[`MCB_EQU_LSB +: 3]; // RULE5
          `MCB_OFF_IEN_A: ien_reg[1:0] <= wdata[1:0]; // RULE6
          `MCB_OFF_ECK: eck_off_reg <= wdata[`MCB_ECK_BIT]; // RULE3
          `MCB_OFF_IEN_B: begin
            ien_reg[2] <= wdata[`MCB_FIRMWARE_COLLISION_EVENT_BIT]; // RULE6
            ien_reg[3] <= wdata[`MCB_PLL_BIT]; // RULE6
            fir_reg <= wdata[`MCB_FIR_LSB +: 2]; // RULE8
          end
          `MCB_OFF_PULSE: py_sel_reg <= wdata[`MCB_PY_BIT];
          `MCB_OFF_IRQ_MASK: mask_reg <= wdata[3:0];
          default: ;
        endcase
      end
      src_d_reg <= irq_src;
      // set wins over a write-one clear in the same cycle
      stat_reg <= (stat_reg & ~(wr_stat ? wdata[3:0] : 4'h0)) | src_rise;
      rdata <= rd_stb ? rd_next : 8'h00;
      digital_pin_nine <= py_sel_reg ? y_energy_pulse : pin_nine_gpio_out; // RULE1
      // gating in a flop costs a cycle of latency; fine for a slow debug clock
      emu_clk_gate <= emu_clk_in & ~eck_off_reg; // RULE3
      emu_erase_grant <= emu_erase_req & ~eck_off_reg; // RULE4
      emu_prog_grant <= emu_prog_req & ~eck_off_reg; // RULE4
      power_equation_select <= equ_reg; // RULE5
      serial_rom_data <= rom_data_reg;
      serial_rom_control <= rom_ctrl_reg;
      decimation_length_select <= fir_reg;
      decimation_cycles <= cyc_next; // RULE8
      cpu_irq <= irq_src & ien_reg & cpu_irq_enable; // RULE6 RULE7
      irq <= |(stat_reg & mask_reg);
    end
  end
endmodule // mcb_config_bits
`default_nettype wire

// file: mcb_defs.vh
// Overview of operation
// RULE1 - when the y pulse pin select bit is set, the y energy pulse drives digital pin nine.
// RULE2 - serial rom data and control are 8-bit read/write registers that clear to zero on reset.
// RULE3 - writing one to the emulator clock off bit stops the clock to the debug emulator port.
// RULE4 - while the emulator clock off bit is set, emulator and programmer erase/program requests are refused.
// RULE5 - a 3-bit power equation select field drives the computation engine and resets to zero.
// RULE6 - four enable bits gate the transfer, calendar, firmware collision and clock lock irq sources, all reset off.
// RULE7 - a peripheral interrupt reaches the processor only when its enable and the processor-side enable are both set.
// RULE8 - a 2-bit decimation length field, reset to one, gives 138/288/384 cycles, or 186/384 in the alternate clock mode.
// RULE9 - written fields update on the next clock edge and read back; unused bits read zero.
`ifndef MCB_DEFS_VH
`define MCB_DEFS_VH
`define MCB_ADDR_W 16
`define MCB_OFF_ROM_DATA 16'h009e
`define MCB_OFF_ROM_CTRL 16'h009f
`define MCB_OFF_EQU 16'h2000
`define MCB_OFF_IEN_A 16'h2002
`define MCB_OFF_ECK 16'h2005
`define MCB_OFF_IEN_B 16'h2007
`define MCB_OFF_PULSE 16'h200f
`define MCB_OFF_IRQ_STAT 16'h2010
`define MCB_OFF_IRQ_MASK 16'h2011
`define MCB_OFF_FIR_CYC 16'h2012
`define MCB_EQU_LSB 5
`define MCB_XFR_BIT 0
`define MCB_RTC_BIT 1
`define MCB_ECK_BIT 5
`define MCB_FIRMWARE_COLLISION_EVENT_BIT 4
`define MCB_PLL_BIT 5
`define MCB_FIR_LSB 2
`define MCB_PY_BIT 2
`define MCB_FIR_RESET 2'h1
`define MCB_FIR_CYC_00 9'd138
`define MCB_FIR_CYC_01 9'd288
`define MCB_FIR_CYC_10 9'd384
`define MCB_FIR_ALT_00 9'd186
`define MCB_FIR_ALT_01 9'd384
`endif

// file: mcb_config_bits_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_config_monitor (
  // clock, reset, register port
  input wire logic clk, rst_n, wr_stb, rd_stb,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata, rdata,
  // pins and steered outputs
  input wire logic y_energy_pulse, pin_nine_gpio_out, digital_pin_nine,
  input wire logic emu_clk_gate, emu_erase_grant, emu_prog_grant,
  input wire logic [2:0] power_equation_select,
  input wire logic [8:0] decimation_cycles,
  input wire logic [3:0] irq_src, cpu_irq_enable, cpu_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence eck_off_wr; wr_stb && addr == 16'h2005 && wdata[5]; endsequence
  // register lands one edge after the strobe, the steered output one edge later
  chk_eck_stop: assert property (eck_off_wr |=> ##2 !emu_clk_gate) else $error("emu clock runs");
  chk_prog_refuse: assert property (eck_off_wr |=> ##2 !emu_erase_grant && !emu_prog_grant)
    else $error("grant while clock off");
  chk_pin_route: assert property (wr_stb && addr == 16'h200f |=> ##2 digital_pin_nine ==
    ($past(wdata[2], 3) ? $past(y_energy_pulse) : $past(pin_nine_gpio_out))) else $error("pin nine");
  chk_equ_pass: assert property (wr_stb && addr == 16'h2000 |=> ##2
    power_equation_select == $past(wdata[7:5], 3)) else $error("equation select");
  chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("rdata idle");
  chk_unmapped_rd: assert property ($past(rd_stb) && $past(addr) == 16'h1234 |-> rdata == 8'h00)
    else $error("unmapped read");
  chk_irq_gate: assert property ((cpu_irq & ~$past(irq_src & cpu_irq_enable)) == 4'h0)
    else $error("ungated irq");
  chk_fir_value: assert property (decimation_cycles inside {9'd0, 9'd138, 9'd186, 9'd288, 9'd384})
    else $error("filter length");
endmodule // mcb_config_monitor
bind mcb_config_bits mcb_config_monitor i_mon (.*);
`default_nettype wire

// file: test_metering_config_bits.sv
`timescale 1ns/1ps
`default_nettype none
module test_metering_config_bits;
  logic clk = 0, rst_n = 0, clk_en = 1, wr_stb = 0, rd_stb = 0, y_energy_pulse = 0;
  logic pin_nine_gpio_out = 0, emu_clk_in = 0, emu_erase_req = 0, emu_prog_req = 0;
  logic fast_clock_flag = 0, mid_clock_flag = 0, digital_pin_nine, emu_clk_gate, irq;
  logic emu_erase_grant, emu_prog_grant;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, rdata, serial_rom_data, serial_rom_control, d;
  logic [3:0] irq_src = 0, cpu_irq_enable = 0, cpu_irq;
  logic [2:0] power_equation_select;
  logic [1:0] decimation_length_select;
  logic [8:0] decimation_cycles;
  int mismatches = 0, num_checks = 0, i;
  mcb_config_bits i_mcb_config_bits (.*);
  initial forever #20 clk = ~clk;
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr_stb <= 1;
    @(posedge clk); wr_stb <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd_stb <= 1;
    @(posedge clk); rd_stb <= 0;
    #1 chk(rdata, e);
  endtask
  task settle; repeat (3) @(posedge clk); #1; endtask
  function logic [8:0] fir(input logic [1:0] c, input logic f, input logic m);
    if (!f && m) return c == 0 ? 9'd186 : c == 1 ? 9'd384 : 9'd0;
    return c == 0 ? 9'd138 : c == 1 ? 9'd288 : c == 2 ? 9'd384 : 9'd0;
  endfunction
  // no handshake to hang on, so one overall limit is enough
  initial begin #400000; mismatches++; summarize(); end
  initial begin
    i = $urandom(32'ha5b7);
    repeat (2) @(posedge clk); rst_n <= 1;
    rd(16'h2007, 8'h04); chk(decimation_cycles, 9'd288);
    rd(16'h009e, 8'h00); rd(16'h009f, 8'h00); rd(16'h2002, 8'h00); rd(16'h1234, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = $urandom; wr(i[0] ? 16'h009f : 16'h009e, d); rd(i[0] ? 16'h009f : 16'h009e, d);
      settle(); chk(i[0] ? serial_rom_control : serial_rom_data, d);
      wr(16'h2000, d); rd(16'h2000, d & 8'he0); settle(); chk(power_equation_select, d[7:5]);
      wr(16'h1234, d); rd(16'h1234, 8'h00);
    end
    for (i = 0; i < 16; i++) begin
      fast_clock_flag <= i[3]; mid_clock_flag <= i[2]; wr(16'h2007, {4'h0, i[1:0], 2'h0});
      rd(16'h2007, {4'h0, i[1:0], 2'h0}); settle();
      chk(decimation_cycles, fir(i[1:0], i[3], i[2]));
      chk(decimation_length_select, i[1:0]);
      rd(16'h2012, fir(i[1:0], i[3], i[2]) >> 1);
    end
    wr(16'h200f, 8'h04);
    for (i = 0; i < 8; i++) begin
      y_energy_pulse <= $urandom; pin_nine_gpio_out <= $urandom; settle();
      chk(digital_pin_nine, y_energy_pulse);
    end
    wr(16'h200f, 8'h00); pin_nine_gpio_out <= 1; settle(); chk(digital_pin_nine, 1);
    emu_clk_in <= 1; emu_erase_req <= 1; emu_prog_req <= 1; settle();
    chk({emu_clk_gate, emu_erase_grant, emu_prog_grant}, 3'h7);
    wr(16'h2005, 8'h20); settle(); chk({emu_clk_gate, emu_erase_grant, emu_prog_grant}, 0);
    rd(16'h2005, 8'h20); wr(16'h2005, 8'h00); settle(); chk(emu_erase_grant, 1);
    for (i = 0; i < 8; i++) begin
      d = $urandom; irq_src <= $urandom; cpu_irq_enable <= $urandom;
      wr(16'h2002, {6'h0, d[1:0]}); wr(16'h2007, {2'h0, d[3:2], 4'h4}); settle();
      chk(cpu_irq, irq_src & cpu_irq_enable & d[3:0]);
    end
    irq_src <= 0; wr(16'h2010, 8'h0f); wr(16'h2011, 8'h02); irq_src <= 4'h3; settle();
    rd(16'h2010, 8'h03); chk(irq, 1);
    wr(16'h2010, 8'h02); settle(); chk(irq, 0); rd(16'h2010, 8'h01);
    // a write while the clock enable is low must leave the register untouched
    wr(16'h009e, 8'h3c); clk_en <= 0; wr(16'h009e, 8'hc3); clk_en <= 1;
    rd(16'h009e, 8'h3c);
    summarize();
  end
endmodule // test_metering_config_bits
`default_nettype wire
